// *** rtl/cim_comparator.sv ***
// Single masked context identifier comparator
`timescale 1ns/1ps
module cim_comparator
  import cim_pkg::*;
(
  input wire logic [31:0] context_id,
  input wire logic [31:0] value,
  input wire logic [31:0] mask,
  output logic match
);

  // Masked bits drop out of the compare
  wire [31:0] diff = (context_id ^ value) & ~mask;
  assign match = (diff == 32'h0000_0000);

endmodule : cim_comparator

// *** rtl/cim_pkg.sv ***
// Package: register map, field layout and carrier types of the context mask block
// ============================================================
// Summary of operation
// - One 32-bit mask register is used when context identifiers are compared.
// - That single mask is shared by every implemented context comparator.
// - A mask bit of 1 removes that bit position from the comparison.
// - The comparator count may be zero and is shown in config code bits 25:24.
// - The mask register exists only from trace version 2.0 onward.
// - Register numbers 0x70 to 0x77 are kept for up to eight vendor registers.
// - Vendor register 0x70 is always present so a debugger can probe it.
// - Enable field 7:4 at zero makes the unit act as if no extension exists.
// - Trace unit reset clears the enable field to zero.
// - The enable field is writable only while config ext bit 11 is set.
// - Presence field 3:0 is read-only and zero means no extensions.
// - Each register sits at byte offset four times its register number.
// - Value and mask registers are write-only unless config ext bit 11 is 1.
// - Each comparator holds a full 32-bit value for comparison.
package cim_pkg;

  // ==========================================================
  // Register numbers and byte offsets
  localparam logic [7:0] CIM_NUM_VALUE0 = 8'h6C;
  localparam logic [7:0] CIM_NUM_MASK = 8'h6F;
  localparam logic [7:0] CIM_NUM_EXT0 = 8'h70;
  localparam logic [7:0] CIM_NUM_EXT_LAST = 8'h77;
  localparam logic [7:0] CIM_NUM_CCR = 8'h01;
  localparam logic [7:0] CIM_NUM_CCER = 8'h7A;
  localparam int CIM_ADDR_W = 10;
  // Byte offset is four times the register number
  localparam logic [9:0] CIM_OFF_VALUE0 = {CIM_NUM_VALUE0, 2'b00};
  localparam logic [9:0] CIM_OFF_MASK = {CIM_NUM_MASK, 2'b00};
  localparam logic [9:0] CIM_OFF_EXT0 = {CIM_NUM_EXT0, 2'b00};
  localparam logic [9:0] CIM_OFF_EXT_LAST = {CIM_NUM_EXT_LAST, 2'b00};
  localparam logic [9:0] CIM_OFF_CCR = {CIM_NUM_CCR, 2'b00};
  localparam logic [9:0] CIM_OFF_CCER = {CIM_NUM_CCER, 2'b00};

  // ==========================================================
  // Field positions
  localparam int CIM_CCR_CNT_LSB = 24;
  localparam int CIM_CCER_RDEN_BIT = 11;
  localparam int CIM_EXT_EN_LSB = 4;
  localparam int CIM_EXT_PRES_LSB = 0;

  // ==========================================================
  // Reset values
  localparam logic [31:0] CIM_MASK_RST = 32'h0000_0000;
  localparam logic [31:0] CIM_VALUE_RST = 32'h0000_0000;
  localparam logic [3:0] CIM_EXT_EN_RST = 4'h0;
  localparam logic [3:0] CIM_EXT_PRES = 4'h0;
  localparam logic [31:0] CIM_CCER_RST = 32'h0000_0000;

  // ==========================================================
  // Bus answers
  localparam logic [1:0] CIM_RESP_OKAY = 2'b00;
  localparam logic [1:0] CIM_RESP_SLVERR = 2'b10;

  // Write request carrier
  typedef struct packed {
    logic [9:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } cim_wreq_t;

  // Read or write response carrier
  typedef struct packed {
    logic [31:0] data;
    logic [1:0] resp;
  } cim_rsp_t;

  // Bus slave states
  typedef enum logic [1:0] {
    CIM_IDLE = 2'b00,
    CIM_RESP = 2'b01
  } cim_state_t;

endpackage : cim_pkg

// *** rtl/cim_top.sv ***
// Context mask and vendor extension registers with AXI4-Lite slave
`timescale 1ns/1ps
module cim_top
  import cim_pkg::*;
#(
  parameter int NUM_CMP = 3,
  parameter bit HAS_MASK = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [CIM_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [CIM_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] context_id,
  output logic [2:0] context_match,
  output logic ext_active
);

  // ==========================================================
  // Write channel capture
  // Address and data are held until both arrived, in either order.
  cim_wreq_t wreq;
  logic aw_held;
  logic w_held;
  cim_state_t wstate;
  logic [1:0] bresp;

  wire aw_take = s_axi_awvalid & ~aw_held & (wstate == CIM_IDLE);
  wire w_take = s_axi_wvalid & ~w_held & (wstate == CIM_IDLE);
  assign s_axi_awready = ~aw_held & (wstate == CIM_IDLE);
  assign s_axi_wready = ~w_held & (wstate == CIM_IDLE);
  wire wr_fire = aw_held & w_held;

  // Capture address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      wreq.addr <= '0;
    end else if (aw_take) begin
      aw_held <= 1'b1;
      wreq.addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  // Capture data and strobes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      wreq.data <= '0;
      wreq.strb <= '0;
    end else if (w_take) begin
      w_held <= 1'b1;
      wreq.data <= s_axi_wdata;
      wreq.strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  // ==========================================================
  // Write decode
  wire [CIM_ADDR_W-1:0] wa = {wreq.addr[CIM_ADDR_W-1:2], 2'b00};
  wire wsel_mask = wr_fire & HAS_MASK & (NUM_CMP > 0) &
                   (wa == CIM_OFF_MASK);
  wire wsel_ext = wr_fire & (wa == CIM_OFF_EXT0);
  wire wsel_ccer = wr_fire & (wa == CIM_OFF_CCER);
  wire wsel_ext_rsv = wr_fire & (wa > CIM_OFF_EXT0) &
                      (wa <= CIM_OFF_EXT_LAST);
  wire wsel_ccr = wr_fire & (wa == CIM_OFF_CCR);
  logic [NUM_CMP-1:0] wsel_val;
  logic [31:0] strb_mask;

  // Byte lane expansion of write strobes
  assign strb_mask = {{8{wreq.strb[3]}}, {8{wreq.strb[2]}},
                      {8{wreq.strb[1]}}, {8{wreq.strb[0]}}};

  // ==========================================================
  // Registers
  logic [31:0] mask_q;
  logic [31:0] value_q [NUM_CMP];
  logic [31:0] ccer_q;
  logic [3:0] ext_en_q;
  wire prog_rd_en = ccer_q[CIM_CCER_RDEN_BIT];

  // One shared 32-bit mask for all comparators
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_q <= CIM_MASK_RST;
    end else if (wsel_mask) begin
      mask_q <= (mask_q & ~strb_mask) | (wreq.data & strb_mask);
    end
  end

  // Comparator value registers and comparators
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CMP; gi++) begin : g_cmp
      logic hit;
      assign wsel_val[gi] = wr_fire &
        (wa == CIM_OFF_VALUE0 + CIM_ADDR_W'(4 * gi));
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          value_q[gi] <= CIM_VALUE_RST;
        end else if (wsel_val[gi]) begin
          value_q[gi] <= (value_q[gi] & ~strb_mask) |
                         (wreq.data & strb_mask);
        end
      end
      cim_comparator u_cmp (
        .context_id(context_id),
        .value(value_q[gi]),
        .mask(HAS_MASK ? mask_q : 32'h0000_0000),
        .match(hit)
      );
      // Software keeps masked value bits zero; no correction here
      if (gi < 3) begin : g_out
        assign context_match[gi] = hit;
      end
    end
    for (gi = NUM_CMP; gi < 3; gi++) begin : g_none
      assign context_match[gi] = 1'b0;
    end
  endgenerate

  // Config ext register, holds the programming readback bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ccer_q <= CIM_CCER_RST;
    end else if (wsel_ccer && wreq.strb[1]) begin
      ccer_q[CIM_CCER_RDEN_BIT] <= wreq.data[CIM_CCER_RDEN_BIT];
    end
  end

  // Extension enable: cleared on reset, gated by bit 11
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_en_q <= CIM_EXT_EN_RST;
    end else if (wsel_ext && prog_rd_en && wreq.strb[0]) begin
      ext_en_q <= wreq.data[CIM_EXT_EN_LSB +: 4];
    end
  end

  // No extensions are built, so the unit behaves plainly either way
  assign ext_active = (ext_en_q != 4'h0) & (CIM_EXT_PRES != 4'h0);

  // Write response; unmapped targets answer SLVERR, writes to the read-only config code answer OKAY
  wire wr_ok = wsel_mask | wsel_ext | wsel_ccer | (|wsel_val) |
               wsel_ext_rsv | wsel_ccr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstate <= CIM_IDLE;
      bresp <= CIM_RESP_OKAY;
    end else begin
      case (wstate)
        CIM_IDLE: begin
          if (wr_fire) begin
            wstate <= CIM_RESP;
            bresp <= wr_ok ? CIM_RESP_OKAY : CIM_RESP_SLVERR;
          end
        end
        CIM_RESP: begin
          if (s_axi_bready) begin
            wstate <= CIM_IDLE;
          end
        end
        default: begin
          wstate <= CIM_IDLE;
        end
      endcase
    end
  end

  assign s_axi_bvalid = (wstate == CIM_RESP);
  assign s_axi_bresp = bresp;

  // ==========================================================
  // Read path
  cim_state_t rstate;
  cim_rsp_t rrsp;
  wire ar_take = s_axi_arvalid & (rstate == CIM_IDLE);
  assign s_axi_arready = (rstate == CIM_IDLE);
  wire [CIM_ADDR_W-1:0] ra = {s_axi_araddr[CIM_ADDR_W-1:2], 2'b00};

  // Read decode, an if-chain over the map
  logic [31:0] rd_data;
  logic [1:0] rd_resp;
  logic [31:0] ccr_word;
  logic [31:0] ext_word;
  logic [31:0] val_rd;

  // Comparator count field
  assign ccr_word = 32'(NUM_CMP[1:0]) << CIM_CCR_CNT_LSB;
  // Presence read-only, enable in its nibble
  assign ext_word = {24'h00_0000, ext_en_q, CIM_EXT_PRES};

  // Value readback select
  always_comb begin
    val_rd = 32'h0000_0000;
    for (int i = 0; i < NUM_CMP; i++) begin
      if (ra == CIM_OFF_VALUE0 + CIM_ADDR_W'(4 * i)) begin
        val_rd = value_q[i];
      end
    end
  end

  wire rsel_val = (ra >= CIM_OFF_VALUE0) &
                  (ra < CIM_OFF_VALUE0 + CIM_ADDR_W'(4 * NUM_CMP));
  wire rsel_mask = HAS_MASK & (NUM_CMP > 0) & (ra == CIM_OFF_MASK);

  // Mapped reads; write-only data reads zero unless bit 11 set
  always_comb begin
    rd_resp = CIM_RESP_OKAY;
    if (ra == CIM_OFF_EXT0) begin
      rd_data = ext_word;
    end else if ((ra > CIM_OFF_EXT0) && (ra <= CIM_OFF_EXT_LAST)) begin
      rd_data = 32'h0000_0000;
    end else if (rsel_mask) begin
      rd_data = prog_rd_en ? mask_q : 32'h0000_0000;
    end else if (rsel_val) begin
      rd_data = prog_rd_en ? val_rd : 32'h0000_0000;
    end else if (ra == CIM_OFF_CCR) begin
      rd_data = ccr_word;
    end else if (ra == CIM_OFF_CCER) begin
      rd_data = ccer_q;
    end else begin
      rd_data = 32'h0000_0000;
      rd_resp = CIM_RESP_SLVERR;
    end
  end

  // Read response register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rstate <= CIM_IDLE;
      rrsp <= '0;
    end else if (ar_take) begin
      rstate <= CIM_RESP;
      rrsp <= '{data: rd_data, resp: rd_resp};
    end else if ((rstate == CIM_RESP) && s_axi_rready) begin
      rstate <= CIM_IDLE;
    end
  end

  assign s_axi_rvalid = (rstate == CIM_RESP);
  assign s_axi_rdata = rrsp.data;
  assign s_axi_rresp = rrsp.resp;

endmodule : cim_top

// *** verif/cim_properties.sv ***
// Checker of register map answers and bus hand-over for the mask block
`timescale 1ns/1ps
module cim_properties
  import cim_pkg::*;
#(
  parameter int NUM_CMP = 3,
  parameter bit HAS_MASK = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [CIM_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [2:0] context_match,
  input wire logic ext_active
);
  // ============================================================
  // Address of the read in flight, so answers can be tied to it
  logic [CIM_ADDR_W-1:0] rd_addr;
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      rd_addr <= s_axi_araddr;
    end
  end
  wire rd_now = s_axi_rvalid;
  wire vend_hit = rd_addr > CIM_OFF_EXT0 && rd_addr <= CIM_OFF_EXT_LAST;

  // ============================================================
  // Properties
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_spare_cmp_low: assert property (
    (context_match >> NUM_CMP) == 3'h0)
    else $error("Unused comparator shows a match");
  a_ext_quiet: assert property (!ext_active)
    else $error("Extension active with none present");
  a_count_field: assert property (
    rd_now && rd_addr == CIM_OFF_CCR |-> s_axi_rdata[25:24] == NUM_CMP)
    else $error("Comparator count field wrong");
  a_probe_reg: assert property (
    rd_now && rd_addr == CIM_OFF_EXT0 |-> s_axi_rdata[3:0] == 4'h0
      && s_axi_rdata[31:8] == 24'h00_0000 && s_axi_rresp == CIM_RESP_OKAY)
    else $error("Extension probe register read wrong");
  a_vendor_raz: assert property (
    rd_now && vend_hit |-> s_axi_rdata == 32'h0000_0000
      && s_axi_rresp == CIM_RESP_OKAY)
    else $error("Reserved vendor register not zero");
  a_mask_mapped: assert property (
    rd_now && rd_addr == CIM_OFF_MASK
      |-> s_axi_rresp == (HAS_MASK ? CIM_RESP_OKAY : CIM_RESP_SLVERR))
    else $error("Mask register presence wrong");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read answer late");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped before taken");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read data dropped before taken");
endmodule : cim_properties

bind cim_top cim_properties #(.NUM_CMP(NUM_CMP), .HAS_MASK(HAS_MASK)) u_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .context_match(context_match),
  .ext_active(ext_active));

// *** verif/context_id_mask_and_ext_regs_tb_top.sv ***
// Register-level testbench of the context mask block
`timescale 1ns/1ps
module context_id_mask_and_ext_regs_tb_top;
  import cim_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, ext_active;
  logic [CIM_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, context_id, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp, brsp;
  logic [2:0] context_match;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;

  cim_top #(.NUM_CMP(3), .HAS_MASK(1'b1)) uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .context_id(context_id), .context_match(context_match),
    .ext_active(ext_active));

  // ============================================================
  // Clock and hang guard
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      complete_run();
    end
  end

  // ============================================================
  // Comparison, verdict and bus tasks
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic complete_run;
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  // Ready goes up with the request and stays up until the answer is seen
  task automatic wr(input logic [9:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hF);
    logic done, ta, tw;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      done = s_axi_bvalid && s_axi_bready;
      brsp = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (done) s_axi_bready <= 1'b0;
    end
  endtask : wr

  task automatic rdc(input string what, input logic [9:0] a,
                     input logic [31:0] exp_d, input logic [1:0] exp_r);
    logic done, ta;
    done = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      done = s_axi_rvalid && s_axi_rready;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (done) s_axi_rready <= 1'b0;
    end
    check(what, rd, exp_d);
    check("read response", {30'h0, rsp}, {30'h0, exp_r});
  endtask : rdc

  task automatic mchk(input logic [31:0] ctx, input logic [2:0] exp);
    @(posedge aclk);
    context_id <= ctx;
    @(negedge aclk);
    check("context_match", {29'h0, context_match}, {29'h0, exp});
  endtask : mchk

  task automatic do_reset;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : do_reset

  // ============================================================
  // Main sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 22'h0;
    {s_axi_wdata, s_axi_wstrb, context_id} = 68'h0;
    do_reset();
    rdc("ext reg", CIM_OFF_EXT0, 32'h0000_0000, CIM_RESP_OKAY);
    rdc("config code", CIM_OFF_CCR, 32'h0000_0003 << CIM_CCR_CNT_LSB,
        CIM_RESP_OKAY);
    check("count", {30'h0, rd[25:24]}, 32'h0000_0003);
    rdc("mask hidden", CIM_OFF_MASK, 32'h0000_0000, CIM_RESP_OKAY);
    wr(CIM_OFF_EXT0, 32'h0000_00F0);
    rdc("enable locked", CIM_OFF_EXT0, 32'h0000_0000, CIM_RESP_OKAY);
    wr(CIM_OFF_CCER, 32'h0000_0800);
    wr(CIM_OFF_EXT0, 32'hFFFF_FFFF);
    rdc("enable open", CIM_OFF_EXT0, 32'h0000_00F0, CIM_RESP_OKAY);
    check("ext_active on", {31'h0, ext_active}, 32'h0000_0000);
    // Enable lives in byte 0, so a write without that lane is dropped
    wr(CIM_OFF_EXT0, 32'h0000_0050, 4'hE);
    rdc("enable lane", CIM_OFF_EXT0, 32'h0000_00F0, CIM_RESP_OKAY);
    wr(CIM_OFF_EXT0, 32'h0000_0000);
    check("ext_active", {31'h0, ext_active}, 32'h0000_0000);
    wr(CIM_OFF_MASK, 32'hFFFF_0000);
    wr(CIM_OFF_VALUE0, 32'h0000_5678);
    wr(CIM_OFF_VALUE0 + 10'h004, 32'h0000_1111);
    wr(CIM_OFF_VALUE0 + 10'h008, 32'h0000_9ABC);
    rdc("mask", CIM_OFF_MASK, 32'hFFFF_0000, CIM_RESP_OKAY);
    mchk(32'hABCD_5678, 3'h1);
    mchk(32'h0000_1111, 3'h2);
    mchk(32'hFFFF_9ABC, 3'h4);
    mchk(32'h5555_9ABD, 3'h0);
    wr(CIM_OFF_MASK, 32'h0000_0000);
    wr(CIM_OFF_VALUE0, 32'hCAFE_F00D);
    mchk(32'hCAFE_F00D, 3'h1);
    mchk(32'h4AFE_F00D, 3'h0);
    for (int i = 1; i < 8; i++) begin
      wr(CIM_OFF_EXT0 + 10'(4 * i), 32'hFFFF_FFFF);
      check("vendor wr", {30'h0, brsp}, {30'h0, CIM_RESP_OKAY});
      rdc("vendor", CIM_OFF_EXT0 + 10'(4 * i), 32'h0, CIM_RESP_OKAY);
    end
    rdc("unmapped", 10'h3F0, 32'h0000_0000, CIM_RESP_SLVERR);
    wr(10'h3F0, 32'hFFFF_FFFF);
    check("unmapped wr", {30'h0, brsp}, {30'h0, CIM_RESP_SLVERR});
    wr(CIM_OFF_EXT0, 32'h0000_00A0);
    do_reset();
    rdc("ext reset", CIM_OFF_EXT0, 32'h0000_0000, CIM_RESP_OKAY);
    complete_run();
  end
endmodule : context_id_mask_and_ext_regs_tb_top
